/* File: src/battery_charger_status_faults.sv */
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "charger_defines.svh"
// Behaviour
// RULE1: State field reads 00 off, 01 trickle, 10 fast; 11 unused.
// RULE2: Indicator LED stays off while charge current is zero.
// RULE3: Indicator toggles at 0.5 Hz while trickle charging.
// RULE4: Indicator blinks at 1 Hz while fast charging.
// RULE5: Indicator pin is open drain: sinks to light, floats otherwise.
// RULE6: Cold indication sets cold flag; hot indication sets hot flag.
// RULE7: Charging suspends while battery is too hot or too cold.
// RULE8: After temperature suspension, trickle charging resumes by itself.
// RULE9: Thermistor monitor enable at bit 3, reset 1; 0 ignores it.
// RULE10: Hot monitor enable at bit 2, reset 1; 0 ignores hot.
// RULE11: Cold monitor enable at bit 1, reset 1; 0 ignores cold.
// RULE12: Monitor enables writable only when unlocked and not ROM config.
// RULE13: Die warning sets its flag and pauses; trickle pause programmable.
// RULE14: Charging resumes once die drops below warning level.
// RULE15: Die shutdown sets its flag, stops charging, shuts down.
// RULE16: Trickle checks battery once at later of 30 min, timeout/4.
// RULE17: Battery below defective threshold then stops, sets defect flag.
// RULE18: Failure clears on voltage recovery, power re-apply or suspend.
// RULE19: On clearing failure, machine returns to its initial state.
// RULE20: Fast with low battery falls back to trickle at once.
// RULE21: Flags set on rising edge of condition, clear when read.
// RULE22: Mask bit at 1 keeps its flag off the summary interrupt.
// RULE23: Blink has equal on/off halves from divided low-frequency clock.
module battery_charger_status_faults
#(
   parameter int unsigned LF_HZ = 32768
)
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   input  wire logic        lowFreqClock,
   input  wire logic        batteryTooHot,
   input  wire logic        batteryTooCold,
   input  wire logic        missingThermistorDetect,
   input  wire logic        dieWarningLevel,
   input  wire logic        dieShutdownLevel,
   input  wire logic        batteryBelowDefective,
   input  wire logic        powerSourcePresent,
   input  wire logic        usbSuspend,
   input  wire logic        romConfig,
   output      logic        trickleChargeOn,
   output      logic        fastChargeOn,
   output      logic        chipShutdown,
   output      logic        chargerSummaryInterrupt,
   output      logic        chargeIndicatorOut,
   output      logic        chargeIndicatorOe
);

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam int unsigned HALF_FAST =
      LF_HZ * `FAST_BLINK_PERIOD_MS / 2000;
   localparam int unsigned HALF_SLOW =
      LF_HZ * `SLOW_BLINK_PERIOD_MS / 2000;
   localparam int unsigned CW = $clog2(HALF_SLOW + 1);
   localparam int unsigned SW = $clog2(LF_HZ + 1);
   localparam int unsigned IN_LF    = 9;
   localparam int unsigned IN_HOT   = 8;
   localparam int unsigned IN_COLD  = 7;
   localparam int unsigned IN_NTC   = 6;
   localparam int unsigned IN_WARN  = 5;
   localparam int unsigned IN_SHUT  = 4;
   localparam int unsigned IN_LOW   = 3;
   localparam int unsigned IN_POWER = 2;
   localparam int unsigned IN_USB   = 1;
   localparam int unsigned IN_ROM   = 0;

   if (LF_HZ < 2 || LF_HZ > 65536)
   begin : badLowFreq
      $error("LF_HZ must lie in 2..65536");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic charger_pkg::chg_field_t fieldOf(
      input charger_pkg::chg_state_t s);
      case (s)
         charger_pkg::CHG_TRICKLE: fieldOf = 2'h1;
         charger_pkg::CHG_FAST:    fieldOf = 2'h2;
         default:                  fieldOf = 2'h0;
      endcase
   endfunction

   function automatic logic [15:0] checkAfter(input logic [3:0] code);
      logic [15:0] minutes;
      logic [15:0] quarter;
      minutes = (code == 4'hF) ? `TIMEOUT_MAX_MIN :
         16'(`TIMEOUT_BASE_MIN + `TIMEOUT_STEP_MIN * {12'h000, code});
      quarter = 16'((minutes * `SECONDS_PER_MINUTE) >> 2);
      if (minutes < (`CHECK_MIN_MINUTES * 16'h0004))
         checkAfter = 16'(`CHECK_MIN_MINUTES * `SECONDS_PER_MINUTE);
      else
         checkAfter = quarter;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [9:0]              syncA;
   logic [9:0]              syncB;
   logic                    lfPrev;
   logic                    powerPrev;
   logic [1:0]              strapCount;
   logic                    romLatched;
   logic                    wrPending;
   logic [11:0]             wrAddr;
   logic [2:0]              monitors;
   logic [3:0]              timeout;
   logic [2:0]              control;
   logic [`FLAG_COUNT-1:0]  mask;
   logic [`FLAG_COUNT-1:0]  flags;
   logic [`FLAG_COUNT-1:0]  condPrev;
   logic                    unlocked;
   charger_pkg::chg_state_t state;
   charger_pkg::chg_state_t next_state;
   charger_pkg::chg_field_t stateField;
   logic [SW-1:0]           secCount;
   logic                    secTick;
   logic [15:0]             trickleSecs;
   logic                    checkDone;
   logic [CW-1:0]           blinkCount;
   logic                    blinkPhase;
   logic [31:0]             readValue;
   logic                    accept;
   logic                    readClear;
   logic                    lfTick;
   logic                    powerReturn;
   logic                    hotS;
   logic                    coldS;
   logic                    warnS;
   logic                    shutS;
   logic                    lowS;
   logic                    tempFault;
   logic                    checkDue;
   logic                    active;
   logic [`FLAG_COUNT-1:0]  cond;
   logic [CW-1:0]           halfLimit;

   // ----------------------------------------------------------------
   // Input synchronisers and derived events
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         syncA     <= 10'h000;
         syncB     <= 10'h000;
         lfPrev    <= 1'b0;
         powerPrev <= 1'b0;
      end
      else
      begin
         syncA     <= {lowFreqClock, batteryTooHot, batteryTooCold,
                       missingThermistorDetect, dieWarningLevel,
                       dieShutdownLevel, batteryBelowDefective,
                       powerSourcePresent, usbSuspend, romConfig};
         syncB     <= syncA;
         lfPrev    <= syncB[IN_LF];
         powerPrev <= syncB[IN_POWER];
      end
   end

   assign lfTick      = syncB[IN_LF] & ~lfPrev;
   assign powerReturn = syncB[IN_POWER] & ~powerPrev;
   assign hotS        = syncB[IN_HOT] & monitors[`HOT_MON_BIT-1]; // RULE10
   assign coldS       = syncB[IN_COLD] & monitors[`COLD_MON_BIT-1]; // RULE11
   assign warnS       = syncB[IN_WARN];
   assign shutS       = syncB[IN_SHUT];
   assign lowS        = syncB[IN_LOW];
   assign tempFault   = hotS | coldS
                      | (syncB[IN_NTC] & monitors[`NTC_MON_BIT-1]); // RULE9

   // Strap caught after reset release
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         strapCount <= 2'h0;
         romLatched <= 1'b0;
      end
      else if (strapCount != 2'h3)
      begin
         strapCount <= 2'(strapCount + 2'h1);
         if (strapCount == 2'h2)
            romLatched <= syncB[IN_ROM];
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   assign accept    = hsel & htrans[1] & hready;
   assign readClear = accept & ~hwrite
                    & (haddr[11:0] == `CHG_FLAGS_ADDR);

   always_comb
   begin
      case (haddr[11:0])
         `CHG_CTRL1_ADDR:   readValue = {28'h0000000, monitors, 1'b0};
         `CHG_CTRL2_ADDR:   readValue = {18'h00000, stateField, timeout,
                                         8'h00};                  // RULE1
         `CHG_FLAGS_ADDR:   readValue = {27'h0000000, flags};
         `CHG_MASK_ADDR:    readValue = {27'h0000000, mask};
         `CHG_CONTROL_ADDR: readValue = {29'h00000000, control};
         `CHG_KEY_ADDR:     readValue = {31'h00000000, unlocked};
         default:           readValue = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrPending <= 1'b0;
         wrAddr    <= 12'h000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         wrPending <= accept & hwrite;
         if (accept)
            wrAddr <= haddr[11:0];
         hrdata <= (accept & ~hwrite) ? readValue : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         monitors <= `MONITOR_RESET;                 // RULE9 RULE10 RULE11
         timeout  <= `TIMEOUT_RESET;
         control  <= `CONTROL_RESET;
         mask     <= `MASK_RESET;
         unlocked <= 1'b0;
      end
      else if (wrPending)
      begin
         case (wrAddr)
            `CHG_CTRL1_ADDR:
               if (unlocked && !romLatched)
                  monitors <= hwdata[`NTC_MON_BIT:`COLD_MON_BIT]; // RULE12
            `CHG_CTRL2_ADDR:
               if (unlocked)
                  timeout <= hwdata[`TIMEOUT_LSB+3:`TIMEOUT_LSB];
            `CHG_MASK_ADDR:    mask    <= hwdata[`FLAG_COUNT-1:0];
            `CHG_CONTROL_ADDR: control <= hwdata[2:0];
            `CHG_KEY_ADDR:     unlocked <= (hwdata == `USER_KEY_VALUE);
            default:           unlocked <= unlocked;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Defect check timing
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         secCount <= '0;
         secTick  <= 1'b0;
      end
      else
      begin
         secTick <= 1'b0;
         if (lfTick)
         begin
            if (secCount >= SW'(LF_HZ - 1))
            begin
               secCount <= '0;
               secTick  <= 1'b1;
            end
            else
               secCount <= SW'(secCount + 1'b1);
         end
      end
   end

   assign checkDue = (state == charger_pkg::CHG_TRICKLE) & ~checkDone
                   & (trickleSecs >= checkAfter(timeout));       // RULE16

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         trickleSecs <= 16'h0000;
         checkDone   <= 1'b0;
      end
      else if (state == charger_pkg::CHG_OFF)
      begin
         trickleSecs <= 16'h0000;
         checkDone   <= 1'b0;
      end
      else if (checkDue)
         checkDone <= 1'b1;                                       // RULE16
      else if (secTick && state == charger_pkg::CHG_TRICKLE && !checkDone)
         trickleSecs <= 16'(trickleSecs + 16'h0001);
   end

   // ----------------------------------------------------------------
   // Charger state machine
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         charger_pkg::CHG_OFF:
            if (control[`CTL_ENABLE_BIT] && !tempFault && !warnS)
               next_state = (control[`CTL_FAST_BIT] && !lowS) ?
                  charger_pkg::CHG_FAST : charger_pkg::CHG_TRICKLE; // RULE20
         charger_pkg::CHG_TRICKLE:
            if (!control[`CTL_ENABLE_BIT])
               next_state = charger_pkg::CHG_OFF;
            else if (checkDue && lowS)
               next_state = charger_pkg::CHG_FAILED;               // RULE17
            else if (tempFault
                     || (warnS && control[`CTL_WARN_PAUSE_BIT]))
               next_state = charger_pkg::CHG_SUSPEND;       // RULE7 RULE13
         charger_pkg::CHG_FAST:
            if (!control[`CTL_ENABLE_BIT])
               next_state = charger_pkg::CHG_OFF;
            else if (tempFault || warnS)
               next_state = charger_pkg::CHG_SUSPEND;       // RULE7 RULE13
            else if (lowS)
               next_state = charger_pkg::CHG_TRICKLE;              // RULE20
         charger_pkg::CHG_SUSPEND:
            if (!control[`CTL_ENABLE_BIT])
               next_state = charger_pkg::CHG_OFF;
            else if (!tempFault && !warnS)
               next_state = charger_pkg::CHG_TRICKLE;        // RULE8 RULE14
         charger_pkg::CHG_FAILED:
            if (!lowS || powerReturn || syncB[IN_USB])
               next_state = charger_pkg::CHG_OFF;            // RULE18 RULE19
         charger_pkg::CHG_HALTED:
            if (powerReturn)
               next_state = charger_pkg::CHG_OFF;
         default:
            next_state = charger_pkg::CHG_OFF;
      endcase
      if (shutS)
         next_state = charger_pkg::CHG_HALTED;                     // RULE15
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state           <= charger_pkg::CHG_OFF;
         stateField      <= 2'h0;
         trickleChargeOn <= 1'b0;
         fastChargeOn    <= 1'b0;
         chipShutdown    <= 1'b0;
      end
      else
      begin
         state           <= next_state;
         stateField      <= fieldOf(next_state);                   // RULE1
         trickleChargeOn <= (next_state == charger_pkg::CHG_TRICKLE);
         fastChargeOn    <= (next_state == charger_pkg::CHG_FAST);
         chipShutdown    <= (next_state == charger_pkg::CHG_HALTED);
      end
   end

   // ----------------------------------------------------------------
   // Flags and summary interrupt
   // ----------------------------------------------------------------
   assign cond = {state == charger_pkg::CHG_FAILED, shutS, warnS,
                  hotS, coldS};

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         condPrev                <= '0;
         flags                   <= '0;
         chargerSummaryInterrupt <= 1'b0;
      end
      else
      begin
         condPrev <= cond;
         flags    <= (readClear ? '0 : flags)
                   | (cond & ~condPrev);             // RULE6 RULE17 RULE21
         chargerSummaryInterrupt <= |(flags & ~mask);              // RULE22
      end
   end

   // ----------------------------------------------------------------
   // Charge indicator
   // ----------------------------------------------------------------
   assign active    = (state == charger_pkg::CHG_TRICKLE)
                    | (state == charger_pkg::CHG_FAST);
   assign halfLimit = (state == charger_pkg::CHG_FAST) ?
                      CW'(HALF_FAST - 1) : CW'(HALF_SLOW - 1); // RULE3 RULE4

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         blinkCount <= '0;
         blinkPhase <= 1'b0;
      end
      else if (!active)
      begin
         blinkCount <= '0;
         blinkPhase <= 1'b0;
      end
      else if (lfTick)
      begin
         if (blinkCount >= halfLimit)
         begin
            blinkCount <= '0;
            blinkPhase <= ~blinkPhase;                             // RULE23
         end
         else
            blinkCount <= CW'(blinkCount + 1'b1);
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         chargeIndicatorOut <= 1'b0;
         chargeIndicatorOe  <= 1'b0;
      end
      else
      begin
         chargeIndicatorOut <= 1'b0;                               // RULE5
         chargeIndicatorOe  <= active & blinkPhase;                // RULE2
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence trickleHot;
      state == charger_pkg::CHG_TRICKLE && hotS && !shutS
      && control[`CTL_ENABLE_BIT];
   endsequence

   sequence lockedCtrlWrite;
      wrPending && wrAddr == `CHG_CTRL1_ADDR && !unlocked;
   endsequence

   field_code_a: assert property (stateField == fieldOf(state)) // RULE1
      else $error("state field disagrees with state");
   led_off_a: assert property (stateField == 2'h0 // RULE2
      |=> !chargeIndicatorOe)
      else $error("indicator lit while charger off");
   open_drain_a: assert property (!chargeIndicatorOut) // RULE5
      else $error("indicator driven high");
   hot_suspend_a: assert property (trickleHot |=> // RULE7
      state == charger_pkg::CHG_SUSPEND && stateField == 2'h0)
      else $error("hot battery did not suspend charging");
   hot_flag_a: assert property ($rose(hotS) |=> flags[`FLAG_HOT]) // RULE21
      else $error("hot flag not set on rising edge");
   mask_gate_a: assert property (chargerSummaryInterrupt // RULE22
      |-> $past(|(flags & ~mask)))
      else $error("summary interrupt without unmasked flag");
   shutdown_halt_a: assert property (shutS |=> // RULE15
      state == charger_pkg::CHG_HALTED ##1 chipShutdown && !fastChargeOn)
      else $error("die shutdown did not halt charger");
   fast_fallback_a: assert property (state == charger_pkg::CHG_FAST // RULE20
      && lowS && !shutS && !tempFault && !warnS && control[0]
      |=> state == charger_pkg::CHG_TRICKLE)
      else $error("low battery did not leave fast charge");
   key_lock_a: assert property (lockedCtrlWrite // RULE12
      |=> $stable(monitors))
      else $error("monitor enables changed while locked");
   fail_clear_a: assert property (state == charger_pkg::CHG_FAILED // RULE18
      && !lowS && !shutS |=> state == charger_pkg::CHG_OFF)
      else $error("failure not cleared on voltage recovery");

endmodule

/* File: src/charger_defines.svh */
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define CHG_CTRL1_INDEX      10'h0A8
`define CHG_CTRL2_INDEX      10'h0A9
`define CHG_CTRL1_ADDR       ({`CHG_CTRL1_INDEX, 2'h0})
`define CHG_CTRL2_ADDR       ({`CHG_CTRL2_INDEX, 2'h0})
`define CHG_FLAGS_ADDR       12'h300
`define CHG_MASK_ADDR        12'h304
`define CHG_CONTROL_ADDR     12'h308
`define CHG_KEY_ADDR         12'h30C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define NTC_MON_BIT          3
`define HOT_MON_BIT          2
`define COLD_MON_BIT         1
`define TIMEOUT_LSB          8
`define STATE_LSB            12
`define CTL_ENABLE_BIT       0
`define CTL_FAST_BIT         1
`define CTL_WARN_PAUSE_BIT   2
`define FLAG_COLD            0
`define FLAG_HOT             1
`define FLAG_WARN            2
`define FLAG_SHUT            3
`define FLAG_FAIL            4
`define FLAG_COUNT           5

// ----------------------------------------------------------------
// Reset values and key
// ----------------------------------------------------------------
`define MONITOR_RESET        3'h7
`define TIMEOUT_RESET        4'hB
`define CONTROL_RESET        3'h0
`define MASK_RESET           5'h00
// Arbitrary unlock value
`define USER_KEY_VALUE       32'h00005A3C

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FAST_BLINK_PERIOD_MS 1000
`define SLOW_BLINK_PERIOD_MS 2000
`define TIMEOUT_BASE_MIN     16'h003C
`define TIMEOUT_STEP_MIN     16'h001E
`define TIMEOUT_MAX_MIN      16'h01FE
`define CHECK_MIN_MINUTES    16'h001E
`define SECONDS_PER_MINUTE   16'h003C

`endif

/* File: src/charger_pkg.sv */
package charger_pkg;

   typedef enum logic [2:0]
   {
      CHG_OFF     = 3'h0,
      CHG_TRICKLE = 3'h1,
      CHG_FAST    = 3'h3,
      CHG_SUSPEND = 3'h2,
      CHG_FAILED  = 3'h6,
      CHG_HALTED  = 3'h7
   } chg_state_t;

   typedef logic [1:0] chg_field_t;

endpackage

/* File: sim/tb.sv */
`timescale 1ns/100ps
`include "charger_defines.svh"
module tb;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        lowFreqClock = 1'b0;
   logic        hot = 1'b0;
   logic        cold = 1'b0;
   logic        ntc = 1'b0;
   logic        warn = 1'b0;
   logic        shut = 1'b0;
   logic        lowBatt = 1'b0;
   logic        power = 1'b1;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        trickleChargeOn;
   logic        fastChargeOn;
   logic        chipShutdown;
   logic        irq;
   logic        indOut;
   logic        indOe;
   logic [31:0] rdata;
   int          n_fail = 0;
   int          compares = 0;
   int          m;
   int          n;

   battery_charger_status_faults #(.LF_HZ(4)) u_dut
   (
      .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .lowFreqClock(lowFreqClock), .batteryTooHot(hot),
      .batteryTooCold(cold), .missingThermistorDetect(ntc),
      .dieWarningLevel(warn), .dieShutdownLevel(shut),
      .batteryBelowDefective(lowBatt), .powerSourcePresent(power),
      .usbSuspend(1'b0), .romConfig(1'b0),
      .trickleChargeOn(trickleChargeOn), .fastChargeOn(fastChargeOn),
      .chipShutdown(chipShutdown), .chargerSummaryInterrupt(irq),
      .chargeIndicatorOut(indOut), .chargeIndicatorOe(indOe)
   );

   always #2.5 clock = ~clock;
   // Low-frequency clock: 4 system cycles per period
   always #10 lowFreqClock = ~lowFreqClock;

   task automatic print_verdict();
      $display("Counts: %0d compares, %0d failures", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("ERROR %0t: %s", $time, msg);
      end
   endtask

   task automatic ahb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask

   task automatic settle();
      repeat (8) @(posedge clock);
   endtask

   // Measures one indicator half period in system cycles
   task automatic blink(input int exp);
      logic last;
      int   k;
      k = 0;
      last = indOe;
      while (indOe === last && k < 400) begin @(posedge clock); k++; end
      last = indOe;
      k = 0;
      while (indOe === last && k < 400) begin @(posedge clock); k++; end
      chk(k >= exp - 1 && k <= exp + 1, "indicator half period");
      chk(indOut === 1'b0, "indicator data not low");
   endtask

   initial
   begin
      #400000;
      n_fail++;
      print_verdict();
   end

   initial
   begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      ahb(0, `CHG_CTRL1_ADDR, 0); chk(rdata === 32'hE, "ctrl1");
      ahb(0, `CHG_CTRL2_ADDR, 0); chk(rdata === 32'hB00, "ctrl2");
      ahb(1, `CHG_CTRL1_ADDR, 0);
      ahb(0, `CHG_CTRL1_ADDR, 0); chk(rdata === 32'hE, "locked");
      ahb(1, `CHG_KEY_ADDR, `USER_KEY_VALUE);
      ahb(1, `CHG_CTRL2_ADDR, 0);
      ahb(0, 12'h3F0, 0); chk(rdata === 32'h0, "unmapped read");
      $display("Test registers done");
      ahb(1, `CHG_CONTROL_ADDR, 1); settle();
      ahb(0, `CHG_CTRL2_ADDR, 0); chk(rdata === 32'h1000, "trickle");
      blink(16);
      for (int i = 0; i < 2; i++)
      begin
         {hot, cold} <= i ? 2'b10 : 2'b01; settle();
         chk(trickleChargeOn === 1'b0, "not suspended");
         chk(irq === 1'b1, "summary low");
         ahb(0, `CHG_FLAGS_ADDR, 0); chk(rdata === (i ? 2 : 1), "flag");
         ahb(0, `CHG_FLAGS_ADDR, 0); chk(rdata === 0, "no clear");
         {hot, cold} <= 2'b00; settle();
         chk(trickleChargeOn === 1'b1, "no resume");
      end
      ahb(1, `CHG_MASK_ADDR, 3); hot <= 1'b1; settle();
      chk(irq === 1'b0, "masked flag raised summary");
      hot <= 1'b0;
      ahb(1, `CHG_CTRL1_ADDR, 32'hA);
      ahb(0, `CHG_FLAGS_ADDR, 0); hot <= 1'b1; settle();
      chk(trickleChargeOn === 1'b1, "hot not ignored");
      ahb(0, `CHG_FLAGS_ADDR, 0); chk(rdata === 0, "hot flag");
      hot <= 1'b0;
      ntc <= 1'b1;
      settle();
      chk(trickleChargeOn === 1'b0, "thermistor ignored");
      ntc <= 1'b0;
      settle();
      $display("Test trickle and temperature done");
      ahb(1, `CHG_CONTROL_ADDR, 0); settle(); settle();
      chk(indOe === 1'b0, "indicator lit when off");
      ahb(1, `CHG_CONTROL_ADDR, 3); settle();
      ahb(0, `CHG_CTRL2_ADDR, 0); chk(rdata === 32'h2000, "fast");
      blink(8);
      warn <= 1'b1;
      settle();
      chk(fastChargeOn === 1'b0, "no warning pause");
      ahb(0, `CHG_FLAGS_ADDR, 0);
      chk(rdata[2] === 1'b1, "warn flag");
      warn <= 1'b0;
      settle();
      chk(trickleChargeOn === 1'b1, "no warning resume");
      warn <= 1'b1;
      settle();
      chk(trickleChargeOn === 1'b1, "trickle paused unasked");
      warn <= 1'b0;
      ahb(1, `CHG_CONTROL_ADDR, 5);
      warn <= 1'b1;
      settle();
      chk(trickleChargeOn === 1'b0, "no trickle pause");
      warn <= 1'b0;
      ahb(1, `CHG_CONTROL_ADDR, 0);
      settle();
      ahb(1, `CHG_CONTROL_ADDR, 3);
      settle();
      lowBatt <= 1'b1;
      m = 0;
      while (trickleChargeOn !== 1'b1 && m < 100) begin @(posedge clock); m++; end
      chk(m <= 8, "no fallback to trickle");
      n = 0;
      while (trickleChargeOn === 1'b1 && n < 40000) begin @(posedge clock); n++; end
      chk(m + n >= 28790 && m + n <= 28815, "check time");
      ahb(0, `CHG_FLAGS_ADDR, 0); chk(rdata[4] === 1'b1, "fail flag");
      lowBatt <= 1'b0; settle();
      chk(fastChargeOn === 1'b1, "no restart");
      $display("Test fast and defect done");
      shut <= 1'b1; settle();
      chk(chipShutdown === 1'b1 && fastChargeOn === 1'b0, "halt");
      ahb(0, `CHG_FLAGS_ADDR, 0); chk(rdata[3] === 1'b1, "shut flag");
      shut <= 1'b0; power <= 1'b0; settle();
      power <= 1'b1; settle();
      chk(chipShutdown === 1'b0, "no power restart");
      $display("Test shutdown done");
      print_verdict();
   end
endmodule
